// File: verilog/standby_pkg.sv
// Package: standby controller constants and carrier types
package standby_pkg;

  // Halt release wait, in clocks (low end of each documented range)
  localparam logic [5:0] HALT_WAIT_VEC   = 6'd28;
  localparam logic [5:0] HALT_WAIT_NOVEC = 6'd20;
  // Stop release wait after the clock comes back, in clocks
  localparam logic [5:0] STOP_WAIT_VEC   = 6'd11;
  localparam logic [5:0] STOP_WAIT_NOVEC = 6'd3;

  // Stop clock-withheld time, typical, in ns, and clock period in ns
  localparam int STOP_HOLD_NS = 27000;
  localparam int CLK_NS       = 25;
  // Typical time, rounded down to whole cycles, never below one
  localparam int STOP_HOLD_CYC_I = (STOP_HOLD_NS / CLK_NS) < 1 ? 1 : (STOP_HOLD_NS / CLK_NS);
  localparam logic [10:0] STOP_HOLD_CYC = 11'(STOP_HOLD_CYC_I);

  // Option and mode bits that steer the low-speed oscillator and watchdog
  typedef struct packed {
    logic wdt_standby_run_opt;
    logic wdt_enable_opt;
    logic wake_timer_clk_sel;
  } standby_opt_t;

  // Run/gate outputs for clocks and peripherals
  typedef struct packed {
    logic cpu_clk_en;
    logic flash_en;
    logic fast_osc_en;
    logic slow_osc_en;
    logic wdt_run;
    logic periph_run;
    logic wake_src_run;
  } standby_gate_t;

  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_HALT,
    MODE_STOP
  } standby_mode_t;

endpackage

// File: verilog/release_wait_counter.sv
// Down counter that times the release wait phases
`timescale 1ns/10ps
module release_wait_counter (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Load and status
  input  wire logic        load,
  input  wire logic [10:0] load_val,
  output logic             done
);
  logic [10:0] cnt_reg;
  logic [10:0] cnt_next;

  // Load wins; otherwise count down to zero and hold
  assign cnt_next = load ? load_val : (cnt_reg != 11'h000 ? cnt_reg - 11'h001 : cnt_reg);
  // No load term: a load driven by done would close a combinational loop
  assign done     = (cnt_reg == 11'h001);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 11'h000;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule

// File: verilog/standby_mode_controller.sv
// Standby controller: halt and stop entry, clock gating and release
`timescale 1ns/10ps
// Overview of operation
// - Halt gates CPU clock, fast oscillator runs
// - Pending unmasked request blocks halt entry
// - Stop gates CPU clock and fast oscillator
// - Pending request at stop: release at once
// - Standby keeps state and port latches
// - Slow oscillator per select, enable, standby option
// - Watchdog runs in standby only if option
// - Peripherals and wake sources operable in halt
// - Stop disables peripherals, wake sources stay
// - Request wakes halt, vectored or next instruction
// - Halt release wait 28 or 20 clocks
// - Stop release waits oscillator stabilization first
// - Stop release 27 us, then 11 or 3
// - Reset ends halt, restarts from vector
// - Reset ends stop, oscillator restarts
module standby_mode_controller
  import standby_pkg::*;
(
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  // CPU decoder strobes
  input  wire logic                       halt_exec,
  input  wire logic                       stop_exec,
  // Interrupt controller
  input  wire logic                       wake_req,
  input  wire logic                       int_ack_en,
  // Option bits
  input  wire standby_pkg::standby_opt_t  opts,
  // Clock and peripheral gates
  output standby_pkg::standby_gate_t      gates,
  output standby_pkg::standby_mode_t      mode,
  output logic                            port_hold,
  // Resume indication to the CPU
  output logic                            resume,
  output logic                            resume_vectored
);

  typedef enum logic [2:0] {
    ST_RUN,
    ST_HALT,
    ST_STOP,
    ST_OSC_HOLD,
    ST_WAIT
  } state_t;

  state_t        state_reg;
  state_t        state_next;
  logic          vec_reg;
  logic          vec_next;
  logic          resume_reg;
  logic          resume_vec_reg;
  logic          cnt_load;
  logic [10:0]   cnt_val;
  logic          cnt_done;
  standby_gate_t gates_next;
  logic          standby_now;
  logic          slow_osc_on;
  logic          from_stop_reg; // Current release began in stop
  logic [10:0]   hold_cnt_reg;

  // Wait length for a given origin and servicing choice
  function automatic logic [10:0] wait_len(input logic from_halt, input logic vec);
    logic [5:0] w;
    w = from_halt ? (vec ? HALT_WAIT_VEC : HALT_WAIT_NOVEC)
                  : (vec ? STOP_WAIT_VEC : STOP_WAIT_NOVEC);
    return {5'h00, w};
  endfunction

  release_wait_counter u_cnt (
    .clk      (clk),
    .rst_n    (rst_n),
    .load     (cnt_load),
    .load_val (cnt_val),
    .done     (cnt_done)
  );

  // Next state; a pending wake request blocks halt and cuts stop short
  always_comb begin
    state_next = state_reg;
    vec_next   = vec_reg;
    cnt_load   = 1'b0;
    cnt_val    = 11'h000;
    unique case (state_reg)
      ST_RUN: begin
        if (halt_exec && !wake_req) begin
          state_next = ST_HALT;
        end else if (stop_exec) begin
          // Stop is entered even when a request waits; release follows at once
          state_next = ST_STOP;
        end
      end
      ST_HALT: begin
        if (wake_req) begin
          vec_next   = int_ack_en;
          cnt_load   = 1'b1;
          cnt_val    = wait_len(1'b1, int_ack_en);
          state_next = ST_WAIT;
        end
      end
      ST_STOP: begin
        if (wake_req) begin
          vec_next   = int_ack_en;
          cnt_load   = 1'b1;
          cnt_val    = STOP_HOLD_CYC;
          state_next = ST_OSC_HOLD;
        end
      end
      ST_OSC_HOLD: begin
        if (cnt_done) begin
          cnt_load   = 1'b1;
          cnt_val    = wait_len(1'b0, vec_reg);
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (cnt_done) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  // Slow oscillator: select bit, or watchdog enable with standby option
  assign slow_osc_on = opts.wake_timer_clk_sel ||
                       (opts.wdt_enable_opt && opts.wdt_standby_run_opt);
  assign standby_now = (state_next != ST_RUN);

  // Gate values for the coming cycle; the oscillator restarts during hold
  always_comb begin
    gates_next.cpu_clk_en   = !standby_now;
    gates_next.flash_en     = !standby_now;
    gates_next.fast_osc_en  = (state_next != ST_STOP);
    gates_next.slow_osc_en  = standby_now ? slow_osc_on : 1'b1;
    gates_next.wdt_run      = standby_now ? opts.wdt_standby_run_opt : 1'b1;
    // Peripherals run in halt; stop cuts them until the release completes
    gates_next.periph_run   = (state_next == ST_RUN) || (state_next == ST_HALT) ||
                              (state_next == ST_WAIT && !from_stop_reg);
    gates_next.wake_src_run = 1'b1;
  end

  // State, gates and resume pulse registers; reset returns to run
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg      <= ST_RUN;
      vec_reg        <= 1'b0;
      from_stop_reg  <= 1'b0;
      gates          <= '{default: 1'b1};
      resume_reg     <= 1'b0;
      resume_vec_reg <= 1'b0;
    end else begin
      state_reg      <= state_next;
      vec_reg        <= vec_next;
      from_stop_reg  <= (state_next == ST_STOP) ? 1'b1 :
                        (state_next == ST_RUN) ? 1'b0 : from_stop_reg;
      gates          <= gates_next;
      resume_reg     <= (state_reg == ST_WAIT) && cnt_done;
      resume_vec_reg <= (state_reg == ST_WAIT) && cnt_done && vec_reg;
    end
  end

  // Mode and port hold: latches and registers are frozen, not cleared
  assign mode = (state_reg == ST_HALT) ? MODE_HALT :
                (state_reg == ST_RUN) ? MODE_RUN : MODE_STOP;
  assign port_hold       = (state_reg != ST_RUN);
  assign resume          = resume_reg;
  assign resume_vectored = resume_vec_reg;

  // Cycles spent with the clock withheld; times the hold apart from the counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_cnt_reg <= 11'h000;
    end else begin
      hold_cnt_reg <= (state_reg == ST_OSC_HOLD) ? hold_cnt_reg + 11'h001 : 11'h000;
    end
  end

  // Checks are disabled in reset, so a reset in mid-wait
  // drops a half-counted release instead of flagging it

  // Halt never entered while a request is pending
  AST_HALT_BLOCK: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_RUN && halt_exec && wake_req) |=> state_reg != ST_HALT)
    else $error("Halt entered with pending request");

  // Fast oscillator keeps running in halt
  AST_HALT_OSC: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_HALT) |-> gates.fast_osc_en && !gates.cpu_clk_en)
    else $error("Halt gating wrong");

  // Stop turns off fast oscillator and CPU clock
  AST_STOP_OSC: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_STOP) |-> !gates.fast_osc_en && !gates.cpu_clk_en)
    else $error("Stop gating wrong");

  // Pending request at stop leaves stop next cycle
  AST_STOP_QUICK: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_STOP && wake_req) |=> state_reg == ST_OSC_HOLD)
    else $error("Stop not left on request");

  // Halt vectored release resumes 29 cycles after request
  AST_HALT_VEC: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_HALT && wake_req && int_ack_en) |-> ##29 resume)
    else $error("Halt vectored wait wrong");

  // Halt plain release resumes 21 cycles after request
  AST_HALT_NOVEC: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_HALT && wake_req && !int_ack_en) |-> ##21 resume && !resume_vectored)
    else $error("Halt plain wait wrong");

  // Watchdog follows the standby option in halt
  AST_WDT: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_HALT && $stable(opts)) |=> gates.wdt_run == opts.wdt_standby_run_opt)
    else $error("Watchdog gate wrong");

  // Slow oscillator follows the select and option bits in stop
  AST_SLOW: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_STOP && $stable(opts)) |=> gates.slow_osc_en ==
      (opts.wake_timer_clk_sel || (opts.wdt_enable_opt && opts.wdt_standby_run_opt)))
    else $error("Slow oscillator gate wrong");

  // Peripherals operable in halt, disabled in stop
  AST_PERIPH: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_HALT |-> gates.periph_run) and
    (state_reg == ST_STOP |-> !gates.periph_run && gates.wake_src_run))
    else $error("Peripheral gating wrong");

  // Port hold in halt and in stop
  AST_PORT: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_HALT || state_reg == ST_STOP) |-> port_hold)
    else $error("Port hold missing");

  // Running state releases the port hold and reports run
  AST_PORT_RUN: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_RUN) |-> !port_hold && mode == MODE_RUN)
    else $error("Port hold in run");

  // Halt strobe without pending request enters halt
  AST_HALT_ENTER: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_RUN && halt_exec && !wake_req) |=> state_reg == ST_HALT)
    else $error("Halt not entered");

  // Stop strobe alone enters stop
  AST_STOP_ENTER: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_RUN && stop_exec && !halt_exec) |=> state_reg == ST_STOP)
    else $error("Stop not entered");

  // Halt is kept until a request arrives
  AST_HALT_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_HALT && !wake_req) |=> state_reg == ST_HALT)
    else $error("Halt left without request");

  // Slow oscillator follows the select and option bits in halt too
  AST_HALT_SLOW: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_HALT && $stable(opts)) |=> gates.slow_osc_en ==
      (opts.wake_timer_clk_sel || (opts.wdt_enable_opt && opts.wdt_standby_run_opt)))
    else $error("Halt slow oscillator gate wrong");

  // Clock withheld, fast oscillator settling, peripherals still off
  AST_HOLD_GATE: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_OSC_HOLD) |-> !gates.cpu_clk_en && gates.fast_osc_en && !gates.periph_run)
    else $error("Hold gating wrong");

  // Hold lasts the full stabilization count
  AST_HOLD_LEN: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_OSC_HOLD && cnt_done) |-> hold_cnt_reg == STOP_HOLD_CYC - 11'h001)
    else $error("Hold length wrong");

  // Stop vectored release resumes 12 cycles after hold ends
  AST_STOP_VEC: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_OSC_HOLD && cnt_done && vec_reg) |-> ##12 resume && resume_vectored)
    else $error("Stop vectored wait wrong");

  // Stop plain release resumes 4 cycles after hold ends
  AST_STOP_NOVEC: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_OSC_HOLD && cnt_done && !vec_reg) |-> ##4 resume && !resume_vectored)
    else $error("Stop plain wait wrong");

  // CPU clock stays off for the whole release wait
  AST_WAIT_CPU: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_WAIT) |-> !gates.cpu_clk_en)
    else $error("CPU clock early in wait");

  // Resume is a single-cycle pulse
  AST_RESUME_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
    resume |=> !resume)
    else $error("Resume longer than one cycle");

  // Vectored flag only rides on a resume pulse
  AST_RESUME_VEC: assert property (@(posedge clk) disable iff (!rst_n)
    resume_vectored |-> resume)
    else $error("Vectored flag without resume");

  // Every gate is open while running
  AST_RUN_GATES: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_RUN) |-> &gates)
    else $error("Gate closed in run");

endmodule

// File: tb/irq_partner.sv
// Interrupt controller stand-in that raises the release request
`timescale 1ns/10ps
module irq_partner (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Request control from the bench
  input  wire logic       arm,
  input  wire logic [7:0] delay,
  // Unmasked request towards the controller
  output logic            wake_req
);
  logic [7:0] cnt_reg;

  // Request rises delay + 1 cycles after arm and stays until software clears it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg  <= 8'h00;
      wake_req <= 1'b0;
    end else if (!arm) begin
      cnt_reg  <= 8'h00;
      wake_req <= 1'b0;
    end else if (cnt_reg >= delay) begin
      wake_req <= 1'b1;
    end else begin
      cnt_reg  <= cnt_reg + 8'h01;
    end
  end
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the standby controller
`timescale 1ns/10ps
module tb_top;
  import standby_pkg::*;
  logic          clk = 1'b0, rst_n = 1'b0, halt_exec = 1'b0, stop_exec = 1'b0;
  logic          int_ack_en = 1'b0, arm = 1'b0, wake_req;
  logic [7:0]    delay = 8'h00;
  standby_opt_t  opts = '0;
  standby_gate_t gates;
  standby_mode_t mode;
  logic          port_hold, resume, resume_vectored;
  int            n_errors = 0, checks_done = 0;

  always #12.5 clk = ~clk;

  standby_mode_controller i_dut (.clk(clk), .rst_n(rst_n), .halt_exec(halt_exec),
    .stop_exec(stop_exec), .wake_req(wake_req), .int_ack_en(int_ack_en), .opts(opts),
    .gates(gates), .mode(mode), .port_hold(port_hold), .resume(resume),
    .resume_vectored(resume_vectored));
  irq_partner i_irq (.clk(clk), .rst_n(rst_n), .arm(arm), .delay(delay), .wake_req(wake_req));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Reference gate levels while parked in halt or stop
  function automatic standby_gate_t exp_g(input logic stp, input standby_opt_t o);
    return '{1'b0, 1'b0, !stp,
             o.wake_timer_clk_sel | (o.wdt_enable_opt & o.wdt_standby_run_opt),
             o.wdt_standby_run_opt, !stp, 1'b1};
  endfunction

  // One strobe, wake, measure release wait; pend means request already up
  task automatic run_case(input logic stp, input standby_opt_t o, input logic ack,
                          input logic pend);
    int n;
    int lo;
    begin
      lo = stp ? int'(STOP_HOLD_CYC) + int'(ack ? STOP_WAIT_VEC : STOP_WAIT_NOVEC)
               : int'(ack ? HALT_WAIT_VEC : HALT_WAIT_NOVEC);
      @(posedge clk);
      opts <= o;
      int_ack_en <= ack;
      arm <= pend;
      // A pending request must already stand when the strobe is taken
      delay <= pend ? 8'h00 : 8'($urandom_range(0, 12));
      @(posedge clk);
      if (pend) @(posedge clk);
      // Converter and stop-disabled peripherals are taken as idle here
      if (stp) stop_exec <= 1'b1;
      else halt_exec <= 1'b1;
      @(posedge clk);
      halt_exec <= 1'b0;
      stop_exec <= 1'b0;
      #1;
      chk(gates, exp_g(stp, o));
      chk(mode, stp ? MODE_STOP : MODE_HALT);
      chk(port_hold, 1'b1);
      if (!pend) begin
        @(posedge clk);
        arm <= 1'b1;
        n = 0;
        while (wake_req !== 1'b1 && n < 50) begin
          @(posedge clk);
          #1;
          n++;
        end
      end
      n = 0;
      do begin
        @(posedge clk);
        #1;
        n++;
      end while (resume !== 1'b1 && n < 2000);
      chk((n - 1 >= lo) && (n - 1 <= lo + (stp ? 2 : 1)), 1'b1);
      chk(resume_vectored, ack);
      // Software clears the request only after resume; peripherals are already running again
      @(posedge clk);
      arm <= 1'b0;
      @(posedge clk);
      #1;
      chk({gates, mode, port_hold}, {7'h7f, MODE_RUN, 1'b0});
    end
  endtask

  // Watchdog: the full sweep needs about 20k cycles
  initial begin
    #(25 * 60000);
    n_errors++;
    end_sim();
  end

  initial begin
    void'($urandom(8));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    // Every option code, both acknowledge settings, halt and stop
    for (int i = 0; i < 32; i++) begin
      run_case(i[4], standby_opt_t'(i[2:0]), i[3], i[4] & 1'($urandom));
    end
    // Pending request refuses halt entry
    @(posedge clk);
    arm <= 1'b1;
    delay <= 8'h00;
    repeat (3) @(posedge clk);
    halt_exec <= 1'b1;
    @(posedge clk);
    halt_exec <= 1'b0;
    #1;
    chk({gates, mode, port_hold}, {7'h7f, MODE_RUN, 1'b0});
    @(posedge clk);
    arm <= 1'b0;
    // Reset in halt and in stop returns everything to run
    for (int s = 0; s < 2; s++) begin
      @(posedge clk);
      if (s == 1) stop_exec <= 1'b1;
      else halt_exec <= 1'b1;
      @(posedge clk);
      halt_exec <= 1'b0;
      stop_exec <= 1'b0;
      repeat (5) @(posedge clk);
      chk(mode, s ? MODE_STOP : MODE_HALT);
      rst_n <= 1'b0;
      #1;
      chk({gates, mode, port_hold, resume}, {7'h7f, MODE_RUN, 2'b00});
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
    end
    run_case(1'b0, standby_opt_t'(3'h5), 1'b1, 1'b0);
    end_sim();
  end
endmodule
